// ---- logic/actuator_status_input_map.sv ----
`timescale 1ns/1ps
`include "actuator_status_input_map.svh"
// How it works
// RULE1 - FC04 reads give three words per actuator at offset 3*(n-1)+part.
// RULE2 - Status word bits 15..8: fault, warning, running, local or shutdown, setpoint, ends.
// RULE3 - Status bits 7..4 torque/limit switches; 3..0 selectors, phase loss, thermal.
// RULE4 - Second word holds the 16-bit position, high byte on top.
// RULE5 - Link word bits 4..6 flag loop 1..3; bits 7..15 read zero.
// RULE6 - Link bit 3 set when neither channel A nor B reaches actuator.
// RULE7 - Link bit 2 means channel B in use, bit 1 channel A.
// RULE8 - Link bit 0 one for operator-interface commands, zero for plant host.
// RULE9 - FC02 reads give six discrete inputs per actuator at 6*(n-1)+i.
// RULE10 - Discrete order: fault, open, closed, remote, torque open, torque close.
// RULE11 - Loop and link status refreshed whenever the monitored state changes.
// RULE12 - Discrete inputs derive from the same stored status word bits.
// RULE13 - Reserved bits and absent actuators read zero, no exception.
module actuator_status_input_map #(
    parameter int ACTUATORS = `ACTUATOR_COUNT
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Status fill from field polling
    input  wire logic        i_stat_we,
    input  wire logic [7:0]  i_stat_actuator,
    input  wire logic [15:0] i_stat_word,
    input  wire logic [15:0] i_stat_position,
    // Link fill from loop monitoring
    input  wire logic        i_link_we,
    input  wire logic [7:0]  i_link_actuator,
    input  wire logic [2:0]  i_link_loop_onehot,
    input  wire logic        i_link_chan_a,
    input  wire logic        i_link_chan_b,
    input  wire logic        i_link_operator_src,
    // Host read request
    input  wire logic        i_rd_req,
    input  wire logic [7:0]  i_rd_fc,
    input  wire logic [15:0] i_rd_addr,
    // Host read answer
    output logic             o_rd_valid,
    output logic [15:0]      o_rd_data,
    output logic             o_rd_illegal_fc
);

    logic [15:0]                       status_reg   [ACTUATORS];
    logic [15:0]                       position_reg [ACTUATORS];
    actuator_status_pkg::link_state_t  link_reg     [ACTUATORS];

    logic [15:0]                       reg_index;
    logic [1:0]                        reg_part;
    logic [15:0]                       di_index;
    logic [2:0]                        di_part;
    logic [15:0]                       link_word;
    logic [15:0]                       status_word;
    logic                              di_bit;
    logic [15:0]                       rd_data_next;
    logic                              illegal_next;
    logic                              reg_in_map;
    logic                              di_in_map;
    logic [15:0]                       reg_word;
    actuator_status_pkg::answer_kind_t kind;

    // One storage slot per actuator; an index past the map hits no slot
    for (genvar n = 0; n < ACTUATORS; n++) begin : g_slot
        logic stat_hit;
        logic link_hit;

        assign stat_hit = i_stat_we && (32'(i_stat_actuator) == n);
        assign link_hit = i_link_we && (32'(i_link_actuator) == n);

        // Status word store
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                status_reg[n] <= `WORD_RESET;
            end else if (stat_hit) begin
                // RULE2 whole status word
                status_reg[n] <= i_stat_word;
            end
        end

        // Position store
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                position_reg[n] <= `WORD_RESET;
            end else if (stat_hit) begin
                // RULE4 position stored intact
                position_reg[n] <= i_stat_position;
            end
        end

        // Link state store
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                link_reg[n] <= '0;
            end else if (link_hit) begin
                // RULE11 refresh on change
                link_reg[n] <= '{loop_onehot:  i_link_loop_onehot,
                                 chan_b:       i_link_chan_b,
                                 chan_a:       i_link_chan_a,
                                 operator_src: i_link_operator_src};
            end
        end
    end

    // Address split
    always_comb begin
        // RULE1 three words per actuator
        reg_index = i_rd_addr / 16'(`WORDS_PER_ACTUATOR);
        reg_part  = 2'(i_rd_addr % 16'(`WORDS_PER_ACTUATOR));
        // RULE9 six inputs per actuator
        di_index  = i_rd_addr / 16'(`INPUTS_PER_ACTUATOR);
        di_part   = 3'(i_rd_addr % 16'(`INPUTS_PER_ACTUATOR));
    end

    // Function code decode
    always_comb begin
        if (i_rd_fc == `FC_READ_INPUT_REG) begin
            kind = actuator_status_pkg::ANS_INPUT_REG;
        end else if (i_rd_fc == `FC_READ_DISCRETE) begin
            kind = actuator_status_pkg::ANS_DISCRETE;
        end else begin
            kind = actuator_status_pkg::ANS_ILLEGAL_FC;
        end
    end

    // Offsets inside the populated map
    always_comb begin
        // RULE13 absent actuator reads zero
        reg_in_map = (i_rd_addr <= `INPUT_REG_LAST) && (32'(reg_index) < ACTUATORS);
        di_in_map  = (i_rd_addr <= `DISCRETE_LAST) && (32'(di_index) < ACTUATORS);
    end

    // Link word of the addressed actuator
    always_comb begin
        actuator_status_pkg::link_state_t lk;
        lk        = '0;
        link_word = `WORD_RESET;
        if (reg_in_map) begin
            lk = link_reg[reg_index[7:0]];
        end
        // RULE5 loop flags, upper bits zero
        link_word[`LK_LOOP_LSB +: 3] = lk.loop_onehot;
        // RULE6 unreachable on both channels
        link_word[`LK_NO_COMM]       = ~lk.chan_a & ~lk.chan_b;
        // RULE7 channel in use
        link_word[`LK_CHAN_B]        = lk.chan_b;
        link_word[`LK_CHAN_A]        = lk.chan_a;
        // RULE8 command source
        link_word[`LK_OPERATOR_SRC]  = lk.operator_src;
    end

    // Input register word
    always_comb begin
        reg_word = `WORD_RESET;
        if (reg_in_map) begin
            // RULE1 part within actuator group
            case (reg_part)
                `PART_STATUS:   reg_word = status_reg[reg_index[7:0]];
                `PART_POSITION: reg_word = position_reg[reg_index[7:0]];
                `PART_LINK:     reg_word = link_word;
                default:        reg_word = `WORD_RESET;
            endcase
        end
    end

    // Discrete input bit
    always_comb begin
        status_word = `WORD_RESET;
        di_bit      = 1'b0;
        if (di_in_map) begin
            // RULE12 shared source with status word
            status_word = status_reg[di_index[7:0]];
            // RULE10 discrete order
            case (di_part)
                `DI_FAULT:        di_bit = status_word[`ST_FAULT];
                `DI_OPEN_POS:     di_bit = status_word[`ST_OPEN_POS];
                `DI_CLOSED_POS:   di_bit = status_word[`ST_CLOSED_POS];
                `DI_REMOTE_SEL:   di_bit = status_word[`ST_REMOTE_SEL];
                `DI_TORQUE_OPEN:  di_bit = status_word[`ST_TORQUE_OPEN];
                `DI_TORQUE_CLOSE: di_bit = status_word[`ST_TORQUE_CLOSE];
                default:          di_bit = 1'b0;
            endcase
        end
    end

    // Answer selection by function code
    always_comb begin
        rd_data_next = `WORD_RESET;
        illegal_next = 1'b0;
        case (kind)
            actuator_status_pkg::ANS_INPUT_REG: rd_data_next = reg_word;
            actuator_status_pkg::ANS_DISCRETE:  rd_data_next = {15'h0000, di_bit};
            default: begin
                illegal_next = 1'b1;
            end
        endcase
    end

    // Answer strobe, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_req;
        end
    end

    // Answer data, zero whenever no answer stands
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_data <= `WORD_RESET;
        end else begin
            o_rd_data <= i_rd_req ? rd_data_next : `WORD_RESET;
        end
    end

    // Unknown function code flag, paired with the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rd_illegal_fc <= 1'b0;
        end else begin
            o_rd_illegal_fc <= i_rd_req & illegal_next;
        end
    end

endmodule : actuator_status_input_map

// ---- logic/actuator_status_input_map.svh ----
`ifndef ACTUATOR_STATUS_INPUT_MAP_SVH
`define ACTUATOR_STATUS_INPUT_MAP_SVH

// Read function codes
`define FC_READ_DISCRETE        8'h02
`define FC_READ_INPUT_REG       8'h04

// Map geometry
`define ACTUATOR_COUNT          240
`define WORDS_PER_ACTUATOR      3
`define INPUTS_PER_ACTUATOR     6
`define INPUT_REG_LAST          16'h02CF
`define DISCRETE_LAST           16'h05C9

// Part index within an actuator's register group
`define PART_STATUS             2'h0
`define PART_POSITION           2'h1
`define PART_LINK               2'h2

// Status word fields
`define ST_FAULT                15
`define ST_WARNING              14
`define ST_RUN_CLOSE            13
`define ST_RUN_OPEN             12
`define ST_LOCAL_OR_SHUTDOWN    11
`define ST_SETPOINT_REACHED     10
`define ST_CLOSED_POS           9
`define ST_OPEN_POS             8
`define ST_TORQUE_CLOSE         7
`define ST_TORQUE_OPEN          6
`define ST_LIMIT_CLOSE          5
`define ST_LIMIT_OPEN           4
`define ST_LOCAL_SEL            3
`define ST_REMOTE_SEL           2
`define ST_PHASE_LOSS           1
`define ST_THERMAL_TRIP         0

// Link word fields
`define LK_LOOP_LSB             4
`define LK_NO_COMM              3
`define LK_CHAN_B               2
`define LK_CHAN_A               1
`define LK_OPERATOR_SRC         0

// Discrete input index within an actuator group
`define DI_FAULT                3'h0
`define DI_OPEN_POS             3'h1
`define DI_CLOSED_POS           3'h2
`define DI_REMOTE_SEL           3'h3
`define DI_TORQUE_OPEN          3'h4
`define DI_TORQUE_CLOSE         3'h5

// Reset values
`define WORD_RESET              16'h0000

`endif

// ---- logic/actuator_status_pkg.sv ----
package actuator_status_pkg;

    // Per-actuator link and command-source state as stored
    typedef struct packed {
        logic [2:0] loop_onehot;
        logic       chan_b;
        logic       chan_a;
        logic       operator_src;
    } link_state_t;

    // Answer kind for a host read
    typedef enum logic [1:0] {
        ANS_INPUT_REG,
        ANS_DISCRETE,
        ANS_ILLEGAL_FC
    } answer_kind_t;

endpackage : actuator_status_pkg

// ---- verification/actuator_status_input_map_properties.sv ----
`timescale 1ns/1ps
`include "actuator_status_input_map.svh"
module map_checker #(
    parameter int ACTUATORS = `ACTUATOR_COUNT
) (
    // Watched ports
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_rd_req,
    input wire logic [7:0]  i_rd_fc,
    input wire logic [15:0] i_rd_addr,
    input wire logic        o_rd_valid,
    input wire logic [15:0] o_rd_data,
    input wire logic        o_rd_illegal_fc
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_reg;
        i_rd_req && i_rd_fc == `FC_READ_INPUT_REG;
    endsequence
    sequence s_di;
        i_rd_req && i_rd_fc == `FC_READ_DISCRETE;
    endsequence
    a_answer_next: assert property (i_rd_req |=> o_rd_valid)
        else $error("read not answered");
    a_no_spurious: assert property (!i_rd_req |=> !o_rd_valid)
        else $error("answer without request");
    a_idle_zero: assert property (!o_rd_valid |-> o_rd_data == 16'h0000)
        else $error("data while idle");
    a_bad_fc: assert property (i_rd_req && i_rd_fc != 8'h02 && i_rd_fc != 8'h04
        |=> o_rd_illegal_fc && o_rd_data == 16'h0000) else $error("bad code not flagged");
    a_good_fc: assert property (s_reg or s_di |=> !o_rd_illegal_fc)
        else $error("good code flagged");
    a_di_bit: assert property (s_di |=> o_rd_data[15:1] == 15'h0000)
        else $error("discrete high bits set");
    a_di_range: assert property (s_di ##0 i_rd_addr >= 6 * ACTUATORS
        |=> o_rd_data == 16'h0000) else $error("discrete beyond map");
    a_reg_range: assert property (s_reg ##0 i_rd_addr > `INPUT_REG_LAST
        |=> o_rd_data == 16'h0000) else $error("register beyond map");
    a_link_bits: assert property (s_reg ##0 (i_rd_addr % 3 == 2 && i_rd_addr < 720)
        |=> o_rd_data[15:7] == 9'h000 && o_rd_data[3] == !(o_rd_data[2] || o_rd_data[1]))
        else $error("link word malformed");
endmodule : map_checker
bind actuator_status_input_map map_checker #(.ACTUATORS(ACTUATORS)) chk (.i_clk, .i_rst,
    .i_rd_req, .i_rd_fc, .i_rd_addr, .o_rd_valid, .o_rd_data, .o_rd_illegal_fc);

// ---- verification/modbus_host_model.sv ----
`timescale 1ns/1ps
module modbus_host_model (
    // Request to the map
    input  wire logic        i_clk,
    output logic             o_rd_req,
    output logic [7:0]       o_rd_fc,
    output logic [15:0]      o_rd_addr,
    // Answer from the map
    input  wire logic        i_rd_valid,
    input  wire logic [15:0] i_rd_data,
    input  wire logic        i_rd_illegal_fc
);
    initial begin
        o_rd_req = 1'b0;
        o_rd_fc = 8'h00;
        o_rd_addr = 16'h0000;
    end
    // Released lines show the inverse of the last value
    task automatic read(input logic [7:0] fc, input logic [15:0] addr,
                        output logic [15:0] data, output logic ok, output logic bad);
        @(posedge i_clk);
        #1;
        o_rd_req = 1'b1;
        o_rd_fc = fc;
        o_rd_addr = addr;
        @(posedge i_clk);
        #1;
        o_rd_req = 1'b0;
        o_rd_fc = ~fc;
        o_rd_addr = ~addr;
        data = i_rd_data;
        ok = i_rd_valid;
        bad = i_rd_illegal_fc;
    endtask : read
endmodule : modbus_host_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        s_we = 1'b0;
    logic        l_we = 1'b0;
    logic [7:0]  s_idx = 8'h00;
    logic [7:0]  l_idx = 8'h00;
    logic [15:0] s_word = 16'h0000;
    logic [15:0] s_pos = 16'h0000;
    logic [5:0]  l_val = 6'h00;
    logic        req;
    logic        ok;
    logic        bad;
    logic        valid;
    logic        illegal;
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] seen;
    int          n_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    always #2.5 i_clk = ~i_clk;
    actuator_status_input_map dut (.i_clk, .i_rst, .i_stat_we(s_we), .i_stat_actuator(s_idx),
        .i_stat_word(s_word), .i_stat_position(s_pos), .i_link_we(l_we), .i_link_actuator(l_idx),
        .i_link_loop_onehot(l_val[5:3]), .i_link_chan_b(l_val[2]), .i_link_chan_a(l_val[1]),
        .i_link_operator_src(l_val[0]), .i_rd_req(req), .i_rd_fc(fc), .i_rd_addr(addr),
        .o_rd_valid(valid), .o_rd_data(data), .o_rd_illegal_fc(illegal));
    modbus_host_model host (.i_clk, .o_rd_req(req), .o_rd_fc(fc), .o_rd_addr(addr),
        .i_rd_valid(valid), .i_rd_data(data), .i_rd_illegal_fc(illegal));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic rd(input logic [7:0] f, input logic [15:0] a, input logic [15:0] exp);
        host.read(f, a, seen, ok, bad);
        check({14'h0000, ok, bad}, 16'h0002);
        check(seen, exp);
    endtask : rd
    task automatic put(input logic [7:0] i, input logic [15:0] w, input logic [15:0] p);
        @(posedge i_clk);
        #1;
        {s_we, s_idx, s_word, s_pos} = {1'b1, i, w, p};
        @(posedge i_clk);
        #1;
        s_we = 1'b0;
    endtask : put
    task automatic t_reset();
        rd(8'h04, 16'h0000, 16'h0000);
        rd(8'h04, 16'h0002, 16'h0008);
    endtask : t_reset
    task automatic t_status();
        put(8'h00, 16'hA5C3, 16'h1234);
        put(8'hEF, 16'h8284, 16'hFEDC);
        put(8'hF0, 16'hFFFF, 16'hFFFF);
        rd(8'h04, 16'h0000, 16'hA5C3);
        rd(8'h04, 16'h0001, 16'h1234);
        rd(8'h04, 16'h02CD, 16'h8284);
        rd(8'h04, 16'h02CE, 16'hFEDC);
    endtask : t_status
    task automatic t_discrete();
        int pos[6] = '{15, 8, 9, 2, 6, 7};
        for (int i = 0; i < 6; i++) begin
            rd(8'h02, 16'(i), (16'hA5C3 >> pos[i]) & 16'h0001);
            rd(8'h02, 16'(1434 + i), (16'h8284 >> pos[i]) & 16'h0001);
        end
    endtask : t_discrete
    task automatic t_link();
        for (int v = 8; v < 40; v++) begin
            @(posedge i_clk);
            #1;
            {l_we, l_idx, l_val} = {1'b1, 8'h01, 6'(v)};
            @(posedge i_clk);
            #1;
            l_we = 1'b0;
            rd(8'h04, 16'h0005, {9'h000, l_val[5:3], ~|l_val[2:1], l_val[2:0]});
            v = (v == 15) ? 15 : (v == 23) ? 31 : v;
        end
    endtask : t_link
    task automatic t_range();
        rd(8'h04, 16'h02D0, 16'h0000);
        rd(8'h02, 16'h05A0, 16'h0000);
        rd(8'h02, 16'h05C9, 16'h0000);
        host.read(8'h03, 16'h0000, seen, ok, bad);
        check({14'h0000, ok, bad}, 16'h0003);
        check(seen, 16'h0000);
    endtask : t_range
    task automatic t_rerun();
        @(posedge i_clk);
        #1;
        i_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        rd(8'h04, 16'h0000, 16'h0000);
        rd(8'h04, 16'h0005, 16'h0008);
        rd(8'h02, 16'h0000, 16'h0000);
    endtask : t_rerun
    initial begin
        repeat (2) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_reset();
        t_status();
        t_discrete();
        t_link();
        t_range();
        t_rerun();
        complete_run();
    end
endmodule : testbench
